//--- rtl/parallel_io_port_registers.sv
// Parallel I/O port registers for ports A, B and N behind an APB slave.
//
// Behaviour
// RULE1: Port N pins work only while the bus width selection shows 8-bit mode.
// RULE2: A port N pin is an input while its direction bit is zero.
// RULE3: A port N pin drives its value bit while its direction bit is one.
// RULE4: Port N value reads give pin levels; writes set levels of output pins.
// RULE5: Ports A and B each have three 16-bit read-write registers.
// RULE6: Reserved bits of every port register read as zero.
// RULE7: Port A function bit one selects the peripheral, zero selects GPIO.
// RULE8: A GPIO port A pin is input at direction zero, output at one.
// RULE9: Reset clears port A function and direction bits, making GPIO inputs.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pio_defines.svh"

module parallel_io_port_registers
  import pio_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                narrow_bus_select,
  input  wire logic [15:0]         porta_pin_in,
  output logic [15:0]              porta_pin_out,
  output logic [15:0]              porta_pin_oe,
  input  wire logic [15:0]         porta_periph_out,
  input  wire logic [15:0]         porta_periph_oe,
  output logic [15:0]              porta_periph_in,
  input  wire logic [15:0]         portb_pin_in,
  output logic [15:0]              portb_pin_out,
  output logic [15:0]              portb_pin_oe,
  input  wire logic [15:0]         portb_periph_out,
  input  wire logic [15:0]         portb_periph_oe,
  output logic [15:0]              portb_periph_in,
  input  wire logic [7:0]          portn_pin_in,
  output logic [7:0]               portn_pin_out,
  output logic [7:0]               portn_pin_oe
);

  regs_t       r_reg;
  regs_t       r_next;
  logic [31:0] reg_rdata;
  logic        reg_hit;
  logic        wr_en;
  logic        narrow_mode;
  logic [15:0] pa_rd;
  logic [15:0] pb_rd;
  logic [7:0]  pn_rd;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a);
    case (a)
      `OFS_PA_FUNC, `OFS_PA_DIR, `OFS_PA_VAL, `OFS_PB_FUNC,
      `OFS_PB_DIR, `OFS_PB_VAL, `OFS_PN_DIR, `OFS_PN_VAL: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction

  // Only the implemented bits of a port are kept; the rest stay zero.
  function automatic word_t keep(input word_t d, input word_t mask);
    keep = d & mask;
  endfunction

  assign reg_hit     = addr_hit(paddr);
  assign narrow_mode = (narrow_bus_select == `NARROW_BUS_SELECT_NARROW);  // RULE1

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  apb_reg_slave u_apb (
    .clock     (clock),
    .rst_n     (rst_n),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .reg_rdata (reg_rdata),
    .reg_hit   (reg_hit),
    .pready    (pready),
    .prdata    (prdata),
    .pslverr   (pslverr),
    .wr_en     (wr_en)
  );

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  // Reads of the value registers show the stored value for GPIO output pins and the pin level for the rest; port N reads zero on a wide bus.
  always_comb begin
    reg_rdata = `RST_PRDATA;
    case (paddr)
      `OFS_PA_FUNC: reg_rdata = {`UPPER_ZERO, keep(r_reg.pa_func, `MASK_PA)};  // RULE6
      `OFS_PA_DIR:  reg_rdata = {`UPPER_ZERO, keep(r_reg.pa_dir, `MASK_PA)};
      `OFS_PA_VAL:  reg_rdata = {`UPPER_ZERO, keep(pa_rd, `MASK_PA)};
      `OFS_PB_FUNC: reg_rdata = {`UPPER_ZERO, keep(r_reg.pb_func, `MASK_PB_FUNC)};
      `OFS_PB_DIR:  reg_rdata = {`UPPER_ZERO, keep(r_reg.pb_dir, `MASK_PB)};
      `OFS_PB_VAL:  reg_rdata = {`UPPER_ZERO, keep(pb_rd, `MASK_PB)};
      `OFS_PN_DIR:  reg_rdata = {`UPPER_ZERO, keep(r_reg.pn_dir, `MASK_PN)};
      `OFS_PN_VAL:  reg_rdata = {`UPPER_ZERO, pn_rd, `RST_PN_LOW};  // RULE4
      default:      reg_rdata = `RST_PRDATA;
    endcase
  end

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    if (wr_en) begin
      case (paddr)  // RULE5
        `OFS_PA_FUNC: r_next.pa_func = keep(pwdata[15:0], `MASK_PA);
        `OFS_PA_DIR:  r_next.pa_dir  = keep(pwdata[15:0], `MASK_PA);
        `OFS_PA_VAL:  r_next.pa_val  = keep(pwdata[15:0], `MASK_PA);
        `OFS_PB_FUNC: r_next.pb_func = keep(pwdata[15:0], `MASK_PB_FUNC);
        `OFS_PB_DIR:  r_next.pb_dir  = keep(pwdata[15:0], `MASK_PB);
        `OFS_PB_VAL:  r_next.pb_val  = keep(pwdata[15:0], `MASK_PB);
        `OFS_PN_DIR:  r_next.pn_dir  = keep(pwdata[15:0], `MASK_PN);
        `OFS_PN_VAL:  r_next.pn_val  = keep(pwdata[15:0], `MASK_PN);  // RULE4
        default:      r_next = r_reg;
      endcase
    end
  end

  // The value registers also reset to zero so that no pin drives garbage
  // the moment software turns a direction bit on.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      r_reg.pa_func <= `RST_WORD;  // RULE9
      r_reg.pa_dir  <= `RST_WORD;  // RULE9
      r_reg.pa_val  <= `RST_WORD;
      r_reg.pb_func <= `RST_WORD;
      r_reg.pb_dir  <= `RST_WORD;
      r_reg.pb_val  <= `RST_WORD;
      r_reg.pn_dir  <= `RST_WORD;
      r_reg.pn_val  <= `RST_WORD;
    end else begin
      r_reg <= r_next;
    end
  end

  // --------------------------------------------------------------------------
  // Pins
  // --------------------------------------------------------------------------
  io_pin_bank #(.W(`PIO_W)) u_port_a (
    .func       (r_reg.pa_func),  // RULE7
    .dir        (r_reg.pa_dir),   // RULE8
    .val        (r_reg.pa_val),
    .enable     (1'b1),
    .pin_in     (porta_pin_in),
    .periph_out (porta_periph_out),
    .periph_oe  (porta_periph_oe),
    .pin_out    (porta_pin_out),
    .pin_oe     (porta_pin_oe),
    .periph_in  (porta_periph_in),
    .rd_val     (pa_rd)
  );

  io_pin_bank #(.W(`PIO_W)) u_port_b (
    .func       (r_reg.pb_func),
    .dir        (r_reg.pb_dir),
    .val        (r_reg.pb_val),
    .enable     (1'b1),
    .pin_in     (portb_pin_in),
    .periph_out (portb_periph_out),
    .periph_oe  (portb_periph_oe),
    .pin_out    (portb_pin_out),
    .pin_oe     (portb_pin_oe),
    .periph_in  (portb_periph_in),
    .rd_val     (pb_rd)
  );

  // Port N has no peripheral function; on a wide bus its pins carry data
  // lines instead, so the bank floats them and reads zero.
  io_pin_bank #(.W(`PN_W)) u_port_n (
    .func       ({`PN_W{1'b0}}),
    .dir        (r_reg.pn_dir[`PN_HI:`PN_LO]),  // RULE2 RULE3
    .val        (r_reg.pn_val[`PN_HI:`PN_LO]),
    .enable     (narrow_mode),                  // RULE1
    .pin_in     (portn_pin_in),
    .periph_out ({`PN_W{1'b0}}),
    .periph_oe  ({`PN_W{1'b0}}),
    .pin_out    (portn_pin_out),
    .pin_oe     (portn_pin_oe),
    .periph_in  (),
    .rd_val     (pn_rd)
  );

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  AST_PN_WIDE_FLOAT: assert property (  // RULE1
    @(posedge clock) disable iff (!rst_n)
    !narrow_mode |-> (portn_pin_oe == {`PN_W{1'b0}}) && (pn_rd == {`PN_W{1'b0}}))
    else $error("Port N drives or reads while the bus is wide.");

  AST_PN_INPUT: assert property (  // RULE2
    @(posedge clock) disable iff (!rst_n)
    (portn_pin_oe & ~r_reg.pn_dir[`PN_HI:`PN_LO]) == {`PN_W{1'b0}})
    else $error("Port N pin drives with its direction bit clear.");

  AST_PN_OUTPUT: assert property (  // RULE3
    @(posedge clock) disable iff (!rst_n)
    narrow_mode |-> (portn_pin_oe == r_reg.pn_dir[`PN_HI:`PN_LO])
                    && (portn_pin_out == r_reg.pn_val[`PN_HI:`PN_LO]))
    else $error("Port N output pin does not drive its value bit.");

  AST_PN_WRITE: assert property (  // RULE4
    @(posedge clock) disable iff (!rst_n)
    (psel && penable && pwrite && paddr == `OFS_PN_VAL)
    |=> portn_pin_out == $past(pwdata[`PN_HI:`PN_LO]))
    else $error("Port N value write did not reach the pins.");

  AST_PN_READ: assert property (  // RULE4
    @(posedge clock) disable iff (!rst_n)
    (psel && !penable && !pwrite && paddr == `OFS_PN_VAL && narrow_mode)
    |=> prdata[`PN_HI:`PN_LO] == $past(portn_pin_in))
    else $error("Port N value read does not show the pin levels.");

  AST_PA_DIR_WRITE: assert property (  // RULE5
    @(posedge clock) disable iff (!rst_n)
    (psel && penable && pwrite && pready && paddr == `OFS_PA_DIR)
    |=> r_reg.pa_dir == ($past(pwdata[15:0]) & `MASK_PA))
    else $error("Port A direction write was not stored.");

  AST_ZERO_WAIT: assert property (  // RULE5
    @(posedge clock) disable iff (!rst_n)
    (psel && !penable) ##1 (psel && penable) |-> pready)
    else $error("Access phase was not answered at once.");

  AST_RESERVED_ZERO: assert property (  // RULE6
    @(posedge clock) disable iff (!rst_n)
    (psel && penable && !pwrite && paddr == `OFS_PA_FUNC)
    |-> (prdata[15:0] & ~`MASK_PA) == `RST_WORD && prdata[31:16] == `UPPER_ZERO)
    else $error("Reserved bits read back as nonzero.");

  AST_PA_FUNCTION: assert property (  // RULE7
    @(posedge clock) disable iff (!rst_n)
    porta_pin_out == ((r_reg.pa_func & porta_periph_out) | (~r_reg.pa_func & r_reg.pa_val)))
    else $error("Port A function select steers the wrong source.");

  AST_PA_DIRECTION: assert property (  // RULE8
    @(posedge clock) disable iff (!rst_n)
    (porta_pin_oe & ~r_reg.pa_func) == (r_reg.pa_dir & ~r_reg.pa_func))
    else $error("Port A GPIO pin direction does not follow its bit.");

  AST_PA_RESET: assert property (  // RULE9
    @(posedge clock)
    !rst_n |=> r_reg.pa_func == `RST_WORD && r_reg.pa_dir == `RST_WORD
               && (porta_pin_oe & ~porta_periph_oe) == `RST_WORD)
    else $error("Reset left port A configured.");

  AST_PA_GPIO_IN_READ: assert property (  // RULE8
    @(posedge clock) disable iff (!rst_n)
    (psel && !penable && !pwrite && paddr == `OFS_PA_VAL)
    |=> ((prdata[15:0] ^ $past(porta_pin_in)) & ~$past(r_reg.pa_dir)
         & ~$past(r_reg.pa_func) & `MASK_PA) == `RST_WORD)
    else $error("Port A input pin value read does not show the pin level.");

  AST_PA_GPIO_OUT_READ: assert property (  // RULE8
    @(posedge clock) disable iff (!rst_n)
    (psel && !penable && !pwrite && paddr == `OFS_PA_VAL)
    |=> ((prdata[15:0] ^ $past(r_reg.pa_val)) & $past(r_reg.pa_dir)
         & ~$past(r_reg.pa_func)) == `RST_WORD)
    else $error("Port A output pin value read does not show the stored value.");

  AST_PA_PERIPH_OE: assert property (  // RULE7
    @(posedge clock) disable iff (!rst_n)
    (porta_pin_oe & r_reg.pa_func) == (porta_periph_oe & r_reg.pa_func))
    else $error("Port A peripheral pin does not follow the peripheral enable.");

  AST_PA_PERIPH_IN: assert property (  // RULE7
    @(posedge clock) disable iff (!rst_n)
    porta_periph_in == (porta_pin_in & r_reg.pa_func))
    else $error("Port A peripheral input is not gated by its function bit.");

  AST_UPPER_ZERO: assert property (  // RULE6
    @(posedge clock) disable iff (!rst_n)
    pready |-> prdata[31:16] == `UPPER_ZERO)
    else $error("Upper half of the read data is not zero.");

  AST_PB_RESERVED_ZERO: assert property (  // RULE6
    @(posedge clock) disable iff (!rst_n)
    (psel && penable && !pwrite && (paddr == `OFS_PB_DIR || paddr == `OFS_PB_VAL))
    |-> (prdata[15:0] & ~`MASK_PB) == `RST_WORD)
    else $error("Port B reserved bits read back as nonzero.");

  AST_PN_RESERVED_ZERO: assert property (  // RULE6
    @(posedge clock) disable iff (!rst_n)
    (psel && penable && !pwrite && (paddr == `OFS_PN_DIR || paddr == `OFS_PN_VAL))
    |-> (prdata[15:0] & ~`MASK_PN) == `RST_WORD)
    else $error("Port N reserved bits read back as nonzero.");

  AST_PN_DIR_WRITE: assert property (  // RULE2
    @(posedge clock) disable iff (!rst_n)
    (psel && penable && pwrite && pready && paddr == `OFS_PN_DIR)
    |=> r_reg.pn_dir == ($past(pwdata[15:0]) & `MASK_PN))
    else $error("Port N direction write was not stored.");

  AST_REFUSED_WRITE: assert property (  // RULE5
    @(posedge clock) disable iff (!rst_n)
    (psel && penable && pwrite && !reg_hit)
    |=> r_reg == $past(r_reg))
    else $error("Write to an unmapped address changed a register.");

endmodule
`default_nettype wire

//--- rtl/pio_defines.svh
// Register offsets, field masks and reset values of the parallel I/O ports.
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// ----------------------------------------------------------------------------
// Bus widths
// ----------------------------------------------------------------------------
`define APB_AW          8
`define APB_DW          32
`define PIO_W           16
`define PN_W            8
`define PN_HI           15
`define PN_LO           8

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_PA_FUNC     8'h00
`define OFS_PA_DIR      8'h04
`define OFS_PA_VAL      8'h08
`define OFS_PB_FUNC     8'h0C
`define OFS_PB_DIR      8'h10
`define OFS_PB_VAL      8'h14
`define OFS_PN_DIR      8'h18
`define OFS_PN_VAL      8'h1C

// ----------------------------------------------------------------------------
// Implemented bit masks and reset values
// ----------------------------------------------------------------------------
`define MASK_PA         16'h17FF
`define MASK_PB_FUNC    16'h00E8
`define MASK_PB         16'h0FE8
`define MASK_PN         16'hFF00
`define RST_WORD        16'h0000
`define RST_PN_LOW      8'h00
`define RST_PRDATA      32'h00000000
`define UPPER_ZERO      16'h0000
`define NARROW_BUS_SELECT_NARROW     1'b0

`endif

//--- rtl/pio_pkg.sv
// Types shared by the parallel I/O port design.
package pio_pkg;

  // --------------------------------------------------------------------------
  // Register words and module state
  // --------------------------------------------------------------------------
  typedef logic [15:0] word_t;

  typedef struct packed {
    word_t pa_func;
    word_t pa_dir;
    word_t pa_val;
    word_t pb_func;
    word_t pb_dir;
    word_t pb_val;
    word_t pn_dir;
    word_t pn_val;
  } regs_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pslverr;
  } apb_state_t;

endpackage

//--- rtl/apb_reg_slave.sv
// APB slave front end: answers with zero wait and registered read data.
`timescale 1ns/10ps
`default_nettype none
`include "pio_defines.svh"

module apb_reg_slave
  import pio_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_hit,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             wr_en
);

  apb_state_t st_reg;
  apb_state_t st_next;

  // --------------------------------------------------------------------------
  // Protocol
  // --------------------------------------------------------------------------
  // Read data is caught in the setup cycle so that prdata comes from a flop.
  always_comb begin
    st_next = st_reg;
    if (psel && !penable) begin
      st_next.prdata  = pwrite ? `RST_PRDATA : reg_rdata;
      st_next.pslverr = !reg_hit;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg.prdata  <= `RST_PRDATA;
      st_reg.pslverr <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pready  = psel && penable;
  assign prdata  = st_reg.prdata;
  assign pslverr = pready && st_reg.pslverr;
  assign wr_en   = pready && pwrite && reg_hit;

endmodule
`default_nettype wire

//--- rtl/io_pin_bank.sv
// Pin steering for one port: direction, function select and readback.
`timescale 1ns/10ps
`default_nettype none

module io_pin_bank #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] func,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] val,
  input  wire logic         enable,
  input  wire logic [W-1:0] pin_in,
  input  wire logic [W-1:0] periph_out,
  input  wire logic [W-1:0] periph_oe,
  output logic [W-1:0]      pin_out,
  output logic [W-1:0]      pin_oe,
  output logic [W-1:0]      periph_in,
  output logic [W-1:0]      rd_val
);

  // --------------------------------------------------------------------------
  // Steering
  // --------------------------------------------------------------------------
  // A disabled bank floats every pin and reads as zero.
  always_comb begin
    pin_out   = (func & periph_out) | (~func & val);
    pin_oe    = enable ? ((func & periph_oe) | (~func & dir)) : {W{1'b0}};
    periph_in = func & pin_in;
    rd_val    = enable ? ((~func & dir & val) | (~(~func & dir) & pin_in)) : {W{1'b0}};
  end

endmodule
`default_nettype wire

//--- verif/pin_board_model.sv
// Board-side model of one port: resolves each pin from the device drive and the board level.
`timescale 1ns/10ps
`default_nettype none

module pin_board_model #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  input  wire logic [W-1:0] level,
  output logic [W-1:0]      pin_in
);
  // The board drives its own level only where the device leaves the pin free,
  // so where both sides drive, the device wins and the contention does not show.
  assign pin_in = (pin_out & pin_oe) | (level & ~pin_oe);
endmodule

`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the parallel I/O port registers.
`timescale 1ns/10ps
`default_nettype none
`include "pio_defines.svh"

module tb_top;
  // --------------------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------------------
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, narrow;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic        rerr;
  logic [15:0] pa_in, pa_out, pa_oe, pa_pout, pa_poe, pa_pin, board_a;
  logic [15:0] pb_in, pb_out, pb_oe, pb_pout, pb_poe, pb_pin, board_b;
  logic [7:0]  pn_in, pn_out, pn_oe, board_n;
  int          err_count, n_compared;
  logic [7:0]  ofs [8] = '{`OFS_PA_FUNC, `OFS_PA_DIR, `OFS_PA_VAL, `OFS_PB_FUNC,
                          `OFS_PB_DIR, `OFS_PB_VAL, `OFS_PN_DIR, `OFS_PN_VAL};
  logic [15:0] msk [8] = '{16'h17FF, 16'h17FF, 16'h17FF, 16'h00E8,
                          16'h0FE8, 16'h0FE8, 16'hFF00, 16'hFF00};

  parallel_io_port_registers i_parallel_io_port_registers (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .narrow_bus_select(narrow),
    .porta_pin_in(pa_in), .porta_pin_out(pa_out), .porta_pin_oe(pa_oe),
    .porta_periph_out(pa_pout), .porta_periph_oe(pa_poe), .porta_periph_in(pa_pin),
    .portb_pin_in(pb_in), .portb_pin_out(pb_out), .portb_pin_oe(pb_oe),
    .portb_periph_out(pb_pout), .portb_periph_oe(pb_poe), .portb_periph_in(pb_pin),
    .portn_pin_in(pn_in), .portn_pin_out(pn_out), .portn_pin_oe(pn_oe));

  pin_board_model #(.W(16)) i_board_a (.pin_out(pa_out), .pin_oe(pa_oe), .level(board_a),
                                       .pin_in(pa_in));
  pin_board_model #(.W(16)) i_board_b (.pin_out(pb_out), .pin_oe(pb_oe), .level(board_b),
                                       .pin_in(pb_in));
  pin_board_model #(.W(8)) i_board_n (.pin_out(pn_out), .pin_oe(pn_oe), .level(board_n),
                                      .pin_in(pn_in));

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never gets an answer.
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Clock, watchdog and tests
  // --------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // About 31 transfers of three cycles each; the limit leaves ample margin.
  initial begin
    repeat (3000) @(posedge clock);
    err_count++;
    summarize();
  end

  initial begin
    err_count = 0; n_compared = 0;
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; narrow = 1'b0;
    pa_pout = 16'h0; pa_poe = 16'h0; pb_pout = 16'h0; pb_poe = 16'h0;
    board_a = 16'hFFFF; board_b = 16'hFFFF; board_n = 8'hFF;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      check(rdata, 32'h0);
    end
    check(pa_oe, 16'h0000);
    // Value reads come from pin levels while pins are inputs, so drive all high.
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, ofs[i], 32'hFFFFFFFF);
      apb(1'b0, ofs[i], 32'h0);
      check(rdata, {16'h0000, msk[i]});
    end
    @(negedge clock);
    check(pb_oe, 16'h0F00);
    check(pb_out, 16'h0F00);
    check(pb_pin, 16'h00E8);
    check({pn_oe, pn_out}, 16'hFFFF);
    // Port A: pin 0 peripheral driving, pin 1 peripheral input, rest GPIO.
    board_a <= 16'hABCD; pa_poe <= 16'h0001; pa_pout <= 16'h0003;
    apb(1'b1, `OFS_PA_FUNC, 32'h3);
    apb(1'b1, `OFS_PA_DIR, 32'hFF);
    apb(1'b1, `OFS_PA_VAL, 32'h1234);
    @(negedge clock);
    check(pa_oe, 16'h00FD);
    check(pa_out & 16'h00FD, 16'h0035);
    check(pa_pin & 16'h0003, 16'h0001);
    apb(1'b0, `OFS_PA_VAL, 32'h0);
    check(rdata, 32'h0335);
    // Port N: low nibble outputs, high nibble inputs from the board.
    board_n <= 8'h3C;
    apb(1'b1, `OFS_PN_DIR, 32'h0F00);
    apb(1'b1, `OFS_PN_VAL, 32'hA500);
    @(negedge clock);
    check(pn_oe, 8'h0F);
    check(pn_out & 8'h0F, 8'h05);
    apb(1'b0, `OFS_PN_VAL, 32'h0);
    check(rdata, 32'h3500);
    narrow <= 1'b1;
    apb(1'b0, `OFS_PN_VAL, 32'h0);
    check(rdata, 32'h0);
    check(pn_oe, 8'h00);
    narrow <= 1'b0;
    // Unmapped address: refused, nothing written.
    apb(1'b1, 8'h20, 32'hFFFF);
    check(rerr, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    check(rerr, 1'b1);
    check(rdata, 32'h0);
    apb(1'b0, `OFS_PA_FUNC, 32'h0);
    check(rdata, 32'h0003);
    // A second reset in mid-run clears port A configuration.
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, `OFS_PA_FUNC, 32'h0);
    check(rdata, 32'h0);
    apb(1'b0, `OFS_PA_DIR, 32'h0);
    check(rdata, 32'h0);
    check(pa_oe, 16'h0000);
    summarize();
  end
endmodule

`default_nettype wire
